// File: ldc_dual_timer.sv
// Dual legacy counter/timer with shared prescaler and register port.
`timescale 1ns/1ps
`default_nettype none
module ldc_dual_timer (
  input wire logic clk_i, // System clock, 10 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable; low freezes all state.
  input wire ldc_pkg::ldc_sfr_req_type sfr_req_i, // Register access.
  output logic [7:0] sfr_rdata_o, // Read data of last cycle's address.
  input wire logic timer0_count_pin_i, // Timer 0 event pin.
  input wire logic timer1_count_pin_i, // Timer 1 event pin.
  input wire logic ext_irq0_input_i, // Gate input for Timer 0.
  input wire logic ext_irq1_input_i, // Gate input for Timer 1.
  input wire logic ext_irq0_polarity_i, // Active level of gate 0.
  input wire logic ext_irq1_polarity_i, // Active level of gate 1.
  input wire logic ext_osc_clk_i, // External oscillator, sampled.
  input wire logic timer0_irq_enable_i, // Timer 0 interrupt enable.
  input wire logic timer1_irq_enable_i, // Timer 1 interrupt enable.
  input wire logic timer0_vector_ack_i, // Vector taken, clears flag 0.
  input wire logic timer1_vector_ack_i, // Vector taken, clears flag 1.
  output logic timer0_irq_o, // Timer 0 interrupt request.
  output logic timer1_irq_o, // Timer 1 interrupt request.
  output logic timer1_overflow_o, // Timer 1 overflow pulse, rate source.
  output logic [3:0] timer23_clock_pick_o // Timer 2/3 clock picks.
);

  // ==========================================================
  // Register state.
  logic [7:0] clock_source_select_reg_r, clock_source_select_reg_nxt; // Clock source select.
  logic [7:0] run_flag_control_reg_r, run_flag_control_reg_nxt; // Run and flag control.
  logic [7:0] timer_mode_reg_r, timer_mode_reg_nxt; // Timer modes.
  logic [7:0] tl0_r, tl0_nxt; // Timer 0 low byte.
  logic [7:0] th0_r, th0_nxt; // Timer 0 high byte.
  logic [7:0] tl1_r, tl1_nxt; // Timer 1 low byte.
  logic [7:0] th1_r, th1_nxt; // Timer 1 high byte.
  logic [7:0] rdata_r, rdata_nxt; // Read data.
  logic t1_ovf_r, t1_ovf_nxt; // Timer 1 overflow pulse.

  // Decoded register writes.
  logic w_ctl, w_mode, w_ck, w_tl0, w_th0, w_tl1, w_th1;

  // ==========================================================
  // Synchronisers for pins, gate inputs and the external clock.
  logic [ldc_pkg::SY_N-1:0] raw; // Asynchronous inputs.
  logic [ldc_pkg::SY_N-1:0] s1_r, s2_r, s3_r; // Three-stage chain.
  logic [ldc_pkg::SY_N-1:0] lvl_r, lvl_nxt; // Accepted level.
  logic [ldc_pkg::SY_N-1:0] fall, rise; // One-cycle edge pulses.

  assign raw = {ext_osc_clk_i, ext_irq1_input_i, ext_irq0_input_i,
                timer1_count_pin_i, timer0_count_pin_i};

  // A level is accepted once stages two and three agree.
  always_comb begin
    lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    fall = lvl_r & ~lvl_nxt;
    rise = ~lvl_r & lvl_nxt;
  end

  // Registers the chain; stage one feeds only stage two.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else if (ce_i) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // ==========================================================
  // Shared prescaler.
  logic [5:0] pre_cnt_r, pre_cnt_nxt; // Divider count.
  logic [5:0] div_last; // Terminal count for the code.
  logic pre_step; // Divider advances this cycle.
  logic pre_tick; // Prescaled clock enable.

  // Divides the system clock, or external clock edges, per code.
  always_comb begin
    div_last = ldc_pkg::PRE_DIV12 - 6'h01;
    if (clock_source_select_reg_r[ldc_pkg::CK_SCA +: 2] == ldc_pkg::SCA_DIV4) begin
      div_last = ldc_pkg::PRE_DIV4 - 6'h01;
    end else if (clock_source_select_reg_r[ldc_pkg::CK_SCA +: 2] == ldc_pkg::SCA_DIV48) begin
      div_last = ldc_pkg::PRE_DIV48 - 6'h01;
    end else if (clock_source_select_reg_r[ldc_pkg::CK_SCA +: 2] == ldc_pkg::SCA_EXT8) begin
      div_last = ldc_pkg::PRE_EXT8 - 6'h01;
    end
    // The external clock counts on synchronised rising edges.
    pre_step = (clock_source_select_reg_r[ldc_pkg::CK_SCA +: 2] == ldc_pkg::SCA_EXT8) ?
               rise[ldc_pkg::SY_XCLK] : 1'b1;
    pre_tick = pre_step && (pre_cnt_r >= div_last);
    pre_cnt_nxt = pre_cnt_r;
    if (pre_tick) begin
      pre_cnt_nxt = 6'h00;
    end else if (pre_step) begin
      pre_cnt_nxt = pre_cnt_r + 6'h01;
    end
  end

  // Registers the divider count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_r <= 6'h00;
    end else if (ce_i) begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  // ==========================================================
  // Clock source, gating and count enables.
  logic [1:0] t0_mode, t1_mode; // Mode fields.
  logic split; // Timer 0 in split mode.
  logic t0_int, t1_int; // Internal clock enables.
  logic t0_run, t1_run; // Run and gate qualification.
  logic t0_inc, t1_inc, th0_inc; // Count enables.

  // Selects each timer's clock and decides whether it counts.
  always_comb begin
    t0_mode = timer_mode_reg_r[ldc_pkg::MD_T0M +: 2];
    t1_mode = timer_mode_reg_r[ldc_pkg::MD_T1M +: 2];
    split = (t0_mode == ldc_pkg::TM_SPLIT);
    t0_int = clock_source_select_reg_r[ldc_pkg::CK_T0PICK] | pre_tick;
    t1_int = clock_source_select_reg_r[ldc_pkg::CK_T1PICK] | pre_tick;
    t0_run = run_flag_control_reg_r[ldc_pkg::CTL_TR0] & (~timer_mode_reg_r[ldc_pkg::MD_TIMER0_PIN_GATING] |
             (lvl_r[ldc_pkg::SY_IRQ0] == ext_irq0_polarity_i));
    // Split mode leaves Timer 1 running on its mode alone.
    t1_run = split | (run_flag_control_reg_r[ldc_pkg::CTL_TR1] & (~timer_mode_reg_r[ldc_pkg::MD_TIMER1_PIN_GATING] |
             (lvl_r[ldc_pkg::SY_IRQ1] == ext_irq1_polarity_i)));
    // Counter mode takes pin edges and the clock pick is ignored, except Timer 1 while Timer 0 is split.
    t0_inc = t0_run & (timer_mode_reg_r[ldc_pkg::MD_CT0] ?
             fall[ldc_pkg::SY_PIN0] : t0_int);
    t1_inc = t1_run & (t1_mode != ldc_pkg::TM_SPLIT) &
             ((timer_mode_reg_r[ldc_pkg::MD_CT1] & ~split) ?
             fall[ldc_pkg::SY_PIN1] : t1_int);
    th0_inc = split & run_flag_control_reg_r[ldc_pkg::CTL_TR1] & t0_int;
  end

  // ==========================================================
  // Counting step: returns {overflow, high byte, low byte}.
  function automatic logic [16:0] step_fn(input logic [1:0] mode,
                                          input logic [7:0] hi,
                                          input logic [7:0] lo);
    logic [16:0] res;
    logic [13:0] c13;
    logic [8:0] s9;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s9 = {1'b0, lo} + 9'h001;
    case (mode)
      ldc_pkg::TM_13: begin
        // Upper three low-byte bits are left untouched.
        res = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      end
      ldc_pkg::TM_16: begin
        res = {1'b0, hi, lo} + 17'h00001;
      end
      ldc_pkg::TM_RLD: begin
        // Wrap reloads the low byte; the high byte is kept.
        res = s9[8] ? {1'b1, hi, hi} : {1'b0, hi, s9[7:0]};
      end
      default: begin
        res = {s9[8], hi, s9[7:0]};
      end
    endcase
    return res;
  endfunction : step_fn

  // ==========================================================
  // Register next values: writes, counting and flags.
  logic [16:0] t0_res, t1_res; // Step results.
  logic [8:0] th0_res; // Split high-byte step.
  logic tf0_set, tf1_set; // Hardware flag sets.

  // Software writes win over counting for the byte written.
  always_comb begin
    w_ctl = sfr_req_i.wr && (sfr_req_i.addr == ldc_pkg::ADDR_CTRL);
    w_mode = sfr_req_i.wr && (sfr_req_i.addr == ldc_pkg::ADDR_MODE);
    w_ck = sfr_req_i.wr && (sfr_req_i.addr == ldc_pkg::ADDR_CKSEL);
    w_tl0 = sfr_req_i.wr && (sfr_req_i.addr == ldc_pkg::ADDR_TL0);
    w_th0 = sfr_req_i.wr && (sfr_req_i.addr == ldc_pkg::ADDR_TH0);
    w_tl1 = sfr_req_i.wr && (sfr_req_i.addr == ldc_pkg::ADDR_TL1);
    w_th1 = sfr_req_i.wr && (sfr_req_i.addr == ldc_pkg::ADDR_TH1);
    // Counting starts from whatever the bytes hold.
    t0_res = t0_inc ? step_fn(t0_mode, th0_r, tl0_r) : {1'b0, th0_r, tl0_r};
    t1_res = t1_inc ? step_fn(t1_mode, th1_r, tl1_r) : {1'b0, th1_r, tl1_r};
    th0_res = th0_inc ? ({1'b0, th0_r} + 9'h001) : {1'b0, th0_r};
    tf0_set = t0_res[16];
    tf1_set = split ? th0_res[8] : t1_res[16];
    t1_ovf_nxt = t1_res[16];
    tl0_nxt = w_tl0 ? sfr_req_i.wdata : t0_res[7:0];
    th0_nxt = w_th0 ? sfr_req_i.wdata : (split ? th0_res[7:0] : t0_res[15:8]);
    tl1_nxt = w_tl1 ? sfr_req_i.wdata : t1_res[7:0];
    th1_nxt = w_th1 ? sfr_req_i.wdata : t1_res[15:8];
    timer_mode_reg_nxt = w_mode ? sfr_req_i.wdata : timer_mode_reg_r;
    clock_source_select_reg_nxt = w_ck ? sfr_req_i.wdata : clock_source_select_reg_r;
    // Flags: write or vector clears, and a hardware set wins.
    run_flag_control_reg_nxt = w_ctl ? sfr_req_i.wdata : run_flag_control_reg_r;
    if (timer0_vector_ack_i) begin
      run_flag_control_reg_nxt[ldc_pkg::CTL_TF0] = 1'b0;
    end
    if (timer1_vector_ack_i) begin
      run_flag_control_reg_nxt[ldc_pkg::CTL_TF1] = 1'b0;
    end
    if (tf0_set) begin
      run_flag_control_reg_nxt[ldc_pkg::CTL_TF0] = 1'b1;
    end
    if (tf1_set) begin
      run_flag_control_reg_nxt[ldc_pkg::CTL_TF1] = 1'b1;
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    if (sfr_req_i.addr == ldc_pkg::ADDR_CTRL) begin
      rdata_nxt = run_flag_control_reg_r;
    end else if (sfr_req_i.addr == ldc_pkg::ADDR_MODE) begin
      rdata_nxt = timer_mode_reg_r;
    end else if (sfr_req_i.addr == ldc_pkg::ADDR_TL0) begin
      rdata_nxt = tl0_r;
    end else if (sfr_req_i.addr == ldc_pkg::ADDR_TL1) begin
      rdata_nxt = tl1_r;
    end else if (sfr_req_i.addr == ldc_pkg::ADDR_TH0) begin
      rdata_nxt = th0_r;
    end else if (sfr_req_i.addr == ldc_pkg::ADDR_TH1) begin
      rdata_nxt = th1_r;
    end else if (sfr_req_i.addr == ldc_pkg::ADDR_CKSEL) begin
      rdata_nxt = clock_source_select_reg_r;
    end else begin
      rdata_nxt = ldc_pkg::REG_RST;
    end
  end

  // Registers all control and count state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_source_select_reg_r <= ldc_pkg::REG_RST;
      run_flag_control_reg_r <= ldc_pkg::REG_RST;
      timer_mode_reg_r <= ldc_pkg::REG_RST;
      tl0_r <= ldc_pkg::REG_RST;
      th0_r <= ldc_pkg::REG_RST;
      tl1_r <= ldc_pkg::REG_RST;
      th1_r <= ldc_pkg::REG_RST;
      rdata_r <= ldc_pkg::REG_RST;
      t1_ovf_r <= 1'b0;
    end else if (ce_i) begin
      clock_source_select_reg_r <= clock_source_select_reg_nxt;
      run_flag_control_reg_r <= run_flag_control_reg_nxt;
      timer_mode_reg_r <= timer_mode_reg_nxt;
      tl0_r <= tl0_nxt;
      th0_r <= th0_nxt;
      tl1_r <= tl1_nxt;
      th1_r <= th1_nxt;
      rdata_r <= rdata_nxt;
      t1_ovf_r <= t1_ovf_nxt;
    end
  end

  // ==========================================================
  // Outputs.
  assign sfr_rdata_o = rdata_r;
  assign timer0_irq_o = run_flag_control_reg_r[ldc_pkg::CTL_TF0] & timer0_irq_enable_i;
  assign timer1_irq_o = run_flag_control_reg_r[ldc_pkg::CTL_TF1] & timer1_irq_enable_i;
  assign timer1_overflow_o = t1_ovf_r;
  assign timer23_clock_pick_o = clock_source_select_reg_r[ldc_pkg::CK_T23 +: 4];

  // ==========================================================
  // Assertions.
  property p_pre_wrap;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && pre_tick |=> pre_cnt_r == 6'h00;
  endproperty
  a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler did not wrap");

  property p_pre12;
    @(posedge clk_i) disable iff (rst_i)
      pre_tick && clock_source_select_reg_r[ldc_pkg::CK_SCA +: 2] == ldc_pkg::SCA_DIV12 |->
      pre_cnt_r == 6'(ldc_pkg::PRE_DIV12 - 6'h01);
  endproperty
  a_pre12: assert property (p_pre12) else $error("divide by 12 wrong");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !t0_run && !split && !w_tl0 && !w_th0 |=> $stable(tl0_r) && $stable(th0_r);
  endproperty
  a_hold: assert property (p_hold) else $error("timer 0 moved while stopped");

  property p_cnt16;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && t0_mode == ldc_pkg::TM_16 && t0_inc && !w_tl0 && !w_th0 |=>
      {th0_r, tl0_r} == 16'({$past(th0_r), $past(tl0_r)} + 16'h0001);
  endproperty
  a_cnt16: assert property (p_cnt16) else $error("16-bit increment wrong");

  property p_wrap13;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && t0_mode == ldc_pkg::TM_13 && t0_inc && !w_tl0 && !w_th0 &&
      {th0_r, tl0_r[4:0]} == ldc_pkg::CNT13_LAST |=>
      run_flag_control_reg_r[ldc_pkg::CTL_TF0] && th0_r == 8'h00 && tl0_r[4:0] == 5'h00;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong");

  property p_reload;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && t0_mode == ldc_pkg::TM_RLD && t0_inc && !w_tl0 && !w_th0 &&
      tl0_r == ldc_pkg::BYTE_LAST |=> tl0_r == $past(th0_r) && run_flag_control_reg_r[ldc_pkg::CTL_TF0];
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload wrong");

  property p_t1_stop;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && t1_mode == ldc_pkg::TM_SPLIT && !w_tl1 && !w_th1 |=>
      $stable(tl1_r) && $stable(th1_r);
  endproperty
  a_t1_stop: assert property (p_t1_stop) else $error("timer 1 counted in mode 3");

  property p_split_tf1;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && th0_inc && th0_r == ldc_pkg::BYTE_LAST |=> run_flag_control_reg_r[ldc_pkg::CTL_TF1];
  endproperty
  a_split_tf1: assert property (p_split_tf1) else $error("split high byte flag lost");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && tf0_set |=> run_flag_control_reg_r[ldc_pkg::CTL_TF0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow flag lost");

  property p_fall;
    @(posedge clk_i) disable iff (rst_i)
      fall[ldc_pkg::SY_PIN0] |-> lvl_r[ldc_pkg::SY_PIN0] &&
      !s2_r[ldc_pkg::SY_PIN0] && !s3_r[ldc_pkg::SY_PIN0];
  endproperty
  a_fall: assert property (p_fall) else $error("false falling edge");

  c_wrap13: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tf0_set && t0_mode == ldc_pkg::TM_13);
  c_reload: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tf0_set && t0_mode == ldc_pkg::TM_RLD);
  c_split: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && split && tf1_set);
  c_pin: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && t0_inc && timer_mode_reg_r[ldc_pkg::MD_CT0]);

endmodule : ldc_dual_timer
`default_nettype wire

// File: ldc_pkg.sv
// Constants and types shared by the dual legacy counter/timer.
package ldc_pkg;
  // ==========================================================
  // Register addresses and reset value.
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_TL0 = 8'h8A;
  localparam logic [7:0] ADDR_TL1 = 8'h8B;
  localparam logic [7:0] ADDR_TH0 = 8'h8C;
  localparam logic [7:0] ADDR_TH1 = 8'h8D;
  localparam logic [7:0] ADDR_CKSEL = 8'h8E;
  localparam logic [7:0] REG_RST = 8'h00;
  // ==========================================================
  // Field positions.
  localparam int unsigned CTL_TF1 = 7;
  localparam int unsigned CTL_TR1 = 6;
  localparam int unsigned CTL_TF0 = 5;
  localparam int unsigned CTL_TR0 = 4;
  localparam int unsigned MD_T0M = 0;
  localparam int unsigned MD_CT0 = 2;
  localparam int unsigned MD_TIMER0_PIN_GATING = 3;
  localparam int unsigned MD_T1M = 4;
  localparam int unsigned MD_CT1 = 6;
  localparam int unsigned MD_TIMER1_PIN_GATING = 7;
  localparam int unsigned CK_SCA = 0;
  localparam int unsigned CK_T0PICK = 2;
  localparam int unsigned CK_T1PICK = 3;
  localparam int unsigned CK_T23 = 4;
  // ==========================================================
  // Mode and prescale codes, divisors and count limits.
  localparam logic [1:0] TM_13 = 2'h0;
  localparam logic [1:0] TM_16 = 2'h1;
  localparam logic [1:0] TM_RLD = 2'h2;
  localparam logic [1:0] TM_SPLIT = 2'h3;
  localparam logic [1:0] SCA_DIV12 = 2'h0;
  localparam logic [1:0] SCA_DIV4 = 2'h1;
  localparam logic [1:0] SCA_DIV48 = 2'h2;
  localparam logic [1:0] SCA_EXT8 = 2'h3;
  localparam logic [5:0] PRE_DIV12 = 6'h0C;
  localparam logic [5:0] PRE_DIV4 = 6'h04;
  localparam logic [5:0] PRE_DIV48 = 6'h30;
  localparam logic [5:0] PRE_EXT8 = 6'h08;
  localparam logic [7:0] BYTE_LAST = 8'hFF;
  localparam logic [12:0] CNT13_LAST = 13'h1FFF;
  // ==========================================================
  // Synchroniser lanes.
  localparam int unsigned SY_PIN0 = 0;
  localparam int unsigned SY_PIN1 = 1;
  localparam int unsigned SY_IRQ0 = 2;
  localparam int unsigned SY_IRQ1 = 3;
  localparam int unsigned SY_XCLK = 4;
  localparam int unsigned SY_N = 5;
  // Register port request: write strobe, address and write data.
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldc_sfr_req_type;
endpackage : ldc_pkg

// File: ldc_pin_model.sv
// Far-side model: event count pins, gate inputs and external oscillator.
`timescale 1ns/1ps
`default_nettype none
module ldc_pin_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ev_load_i, // Loads the event counts of both pins.
  input wire logic [7:0] ev0_n_i,
  input wire logic [7:0] ev1_n_i,
  input wire logic timer0_pin_gating_i,
  input wire logic timer1_pin_gating_i,
  input wire logic osc_en_i, // Oscillator runs only while high.
  output logic pin0_o,
  output logic pin1_o,
  output logic timer0_pin_gating_o,
  output logic timer1_pin_gating_o,
  output logic osc_o,
  output logic busy_o
);
  // ==========================================================
  // Event state; pins idle high as behind a pull-up.
  logic [7:0] left0_r;
  logic [7:0] left1_r;
  logic [1:0] ph_r;
  logic [1:0] osc_r;
  // Each event is two cycles low then two high, never faster.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left0_r <= 8'h00;
      left1_r <= 8'h00;
      ph_r <= 2'h0;
      osc_r <= 2'h0;
    end else begin
      osc_r <= osc_en_i ? osc_r + 2'h1 : 2'h0;
      if (ev_load_i) begin
        left0_r <= ev0_n_i;
        left1_r <= ev1_n_i;
        ph_r <= 2'h0;
      end else if (busy_o) begin
        ph_r <= ph_r + 2'h1;
        if (ph_r == 2'h3) begin
          left0_r <= (left0_r != 8'h00) ? left0_r - 8'h01 : 8'h00;
          left1_r <= (left1_r != 8'h00) ? left1_r - 8'h01 : 8'h00;
        end
      end
    end
  end
  assign busy_o = (left0_r != 8'h00) || (left1_r != 8'h00);
  assign pin0_o = !((left0_r != 8'h00) && !ph_r[1]);
  assign pin1_o = !((left1_r != 8'h00) && !ph_r[1]);
  assign timer0_pin_gating_o = timer0_pin_gating_i;
  assign timer1_pin_gating_o = timer1_pin_gating_i;
  // The oscillator holds each level two cycles and stands low when stopped.
  assign osc_o = osc_r[1];
endmodule : ldc_pin_model
`default_nettype wire

// File: test_legacy_dual_counter_timer.sv
// Self-checking testbench for the dual legacy counter/timer.
`timescale 1ns/1ps
`default_nettype none
module test_legacy_dual_counter_timer;
  // ==========================================================
  // Stimulus, observation and bookkeeping.
  logic clk_i;
  logic rst_i;
  ldc_pkg::ldc_sfr_req_type req;
  logic [7:0] rdata;
  logic ev_load, osc_en, g0, g1, pol0, pol1, en0, en1, ack0, ack1;
  logic [7:0] ev0_n;
  logic [7:0] ev1_n;
  logic pin0, pin1, timer0_pin_gating, timer1_pin_gating, osc, busy, irq0, irq1, ovf1;
  logic [3:0] picks;
  int n_fail;
  int compares;
  localparam int PS_WIN [4] = '{48, 48, 48, 64};
  localparam logic [7:0] PS_EXP [4] = '{8'h04, 8'h0C, 8'h01, 8'h02};
  ldc_dual_timer dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .timer0_count_pin_i(pin0), .timer1_count_pin_i(pin1),
    .ext_irq0_input_i(timer0_pin_gating), .ext_irq1_input_i(timer1_pin_gating), .ext_irq0_polarity_i(pol0),
    .ext_irq1_polarity_i(pol1), .ext_osc_clk_i(osc), .timer0_irq_enable_i(en0),
    .timer1_irq_enable_i(en1), .timer0_vector_ack_i(ack0), .timer1_vector_ack_i(ack1),
    .timer0_irq_o(irq0), .timer1_irq_o(irq1), .timer1_overflow_o(ovf1),
    .timer23_clock_pick_o(picks));
  ldc_pin_model far (.clk_i(clk_i), .rst_i(rst_i), .ev_load_i(ev_load), .ev0_n_i(ev0_n),
    .ev1_n_i(ev1_n), .timer0_pin_gating_i(g0), .timer1_pin_gating_i(g1), .osc_en_i(osc_en), .pin0_o(pin0),
    .pin1_o(pin1), .timer0_pin_gating_o(timer0_pin_gating), .timer1_pin_gating_o(timer1_pin_gating), .osc_o(osc), .busy_o(busy));
  // Free-running 10 MHz system clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // Compares one value and reports a difference.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // Register write: strobe held for exactly one sampling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_i) req.wr <= 1'b0;
  endtask : wr
  // Register read: data shows one edge after the address.
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string name);
    @(posedge clk_i) req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    #1;
    chk(name, e & m, rdata & m);
  endtask : rd
  // Holds the Timer 0 gate active for exactly n cycles.
  task automatic pulse0(input int n);
    @(posedge clk_i) g0 <= 1'b1;
    cyc(n);
    g0 <= 1'b0;
  endtask : pulse0
  // Reset values, an unmapped address and the clock select register.
  task automatic t_regs;
    for (int i = 0; i < 7; i++) begin
      rd(ldc_pkg::ADDR_CTRL + 8'(i), 8'hFF, ldc_pkg::REG_RST, "reset value");
    end
    wr(8'h90, 8'h5A);
    rd(8'h90, 8'hFF, 8'h00, "unmapped");
    wr(ldc_pkg::ADDR_CKSEL, 8'hA5);
    rd(ldc_pkg::ADDR_CKSEL, 8'hFF, 8'hA5, "cksel");
    chk("picks", 8'h0A, {4'h0, picks});
    $display("test regs done");
  endtask : t_regs
  // Gated 16-bit timer wraps, flags, interrupts and is acknowledged.
  task automatic t_mode16;
    wr(ldc_pkg::ADDR_CKSEL, 8'h04);
    wr(ldc_pkg::ADDR_MODE, 8'h09);
    wr(ldc_pkg::ADDR_TL0, 8'hFD);
    wr(ldc_pkg::ADDR_TH0, 8'hFF);
    wr(ldc_pkg::ADDR_CTRL, 8'h10);
    cyc(10);
    rd(ldc_pkg::ADDR_TL0, 8'hFF, 8'hFD, "tl0 held");
    pulse0(5);
    cyc(8);
    rd(ldc_pkg::ADDR_TL0, 8'hFF, 8'h02, "tl0");
    rd(ldc_pkg::ADDR_TH0, 8'hFF, 8'h00, "th0");
    rd(ldc_pkg::ADDR_CTRL, 8'hFF, 8'h30, "ctrl");
    chk("irq0", 8'h01, {7'h00, irq0});
    @(posedge clk_i) ack0 <= 1'b1;
    @(posedge clk_i) ack0 <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("irq0 acked", 8'h00, {7'h00, irq0});
    $display("test mode16 done");
  endtask : t_mode16
  // Timer 1 in 13-bit mode, gate active low, interrupt disabled.
  task automatic t_mode13;
    wr(ldc_pkg::ADDR_CTRL, 8'h00);
    wr(ldc_pkg::ADDR_MODE, 8'h80);
    wr(ldc_pkg::ADDR_CKSEL, 8'h08);
    wr(ldc_pkg::ADDR_TL1, 8'h1F);
    wr(ldc_pkg::ADDR_TH1, 8'hFF);
    wr(ldc_pkg::ADDR_CTRL, 8'h40);
    cyc(10);
    rd(ldc_pkg::ADDR_TL1, 8'h1F, 8'h1F, "tl1 held");
    @(posedge clk_i) g1 <= 1'b0;
    cyc(2);
    g1 <= 1'b1;
    cyc(8);
    rd(ldc_pkg::ADDR_TL1, 8'h1F, 8'h01, "tl1");
    rd(ldc_pkg::ADDR_TH1, 8'hFF, 8'h00, "th1");
    rd(ldc_pkg::ADDR_CTRL, 8'hFF, 8'hC0, "ctrl");
    chk("irq1 masked", 8'h00, {7'h00, irq1});
    wr(ldc_pkg::ADDR_CTRL, 8'h00);
    rd(ldc_pkg::ADDR_CTRL, 8'hFF, 8'h00, "flag cleared");
    $display("test mode13 done");
  endtask : t_mode13
  // Auto-reload: low byte preloaded before the run bit is set.
  task automatic t_reload;
    wr(ldc_pkg::ADDR_MODE, 8'h0A);
    wr(ldc_pkg::ADDR_CKSEL, 8'h04);
    wr(ldc_pkg::ADDR_TH0, 8'hF0);
    wr(ldc_pkg::ADDR_TL0, 8'hFE);
    wr(ldc_pkg::ADDR_CTRL, 8'h10);
    pulse0(3);
    cyc(8);
    rd(ldc_pkg::ADDR_TL0, 8'hFF, 8'hF1, "tl0 reload");
    rd(ldc_pkg::ADDR_TH0, 8'hFF, 8'hF0, "th0 kept");
    rd(ldc_pkg::ADDR_CTRL, 8'hFF, 8'h30, "ctrl");
    $display("test reload done");
  endtask : t_reload
  // Prescaler: ticks counted in a 48-cycle gate window, 64 cycles for the external clock, all codes.
  task automatic t_prescale;
    wr(ldc_pkg::ADDR_MODE, 8'h09);
    for (int k = 0; k < 4; k++) begin
      wr(ldc_pkg::ADDR_CTRL, 8'h00);
      wr(ldc_pkg::ADDR_TL0, 8'h00);
      wr(ldc_pkg::ADDR_TH0, 8'h00);
      wr(ldc_pkg::ADDR_CKSEL, {6'h00, 2'(k)});
      osc_en <= (k == 3);
      wr(ldc_pkg::ADDR_CTRL, 8'h10);
      cyc(60);
      pulse0(PS_WIN[k]);
      cyc(8);
      rd(ldc_pkg::ADDR_TL0, 8'hFF, PS_EXP[k], "prescaled count");
    end
    osc_en <= 1'b0;
    $display("test prescale done");
  endtask : t_prescale
  // Counter mode on both pins; clock pick bits must be ignored.
  task automatic t_counter;
    wr(ldc_pkg::ADDR_CTRL, 8'h00);
    wr(ldc_pkg::ADDR_MODE, 8'h55);
    wr(ldc_pkg::ADDR_CKSEL, 8'h0C);
    for (int i = 0; i < 4; i++) wr(ldc_pkg::ADDR_TL0 + 8'(i), 8'h00);
    wr(ldc_pkg::ADDR_CTRL, 8'h50);
    @(posedge clk_i) ev_load <= 1'b1;
    ev0_n <= 8'h03;
    ev1_n <= 8'h02;
    @(posedge clk_i) ev_load <= 1'b0;
    #1;
    for (int i = 0; i < 100 && busy; i++) @(posedge clk_i);
    chk("events sent", 8'h00, {7'h00, busy});
    if (busy) report_and_stop();
    cyc(8);
    rd(ldc_pkg::ADDR_TL0, 8'hFF, 8'h03, "tl0 events");
    rd(ldc_pkg::ADDR_TL1, 8'hFF, 8'h02, "tl1 events");
    $display("test counter done");
  endtask : t_counter
  // Split mode: high byte on Timer 1 run and flag; Timer 1 flagless.
  task automatic t_split;
    int n_ovf;
    int n_irq;
    n_ovf = 0;
    n_irq = 0;
    wr(ldc_pkg::ADDR_CTRL, 8'h00);
    en1 <= 1'b1;
    wr(ldc_pkg::ADDR_TL1, 8'hFF);
    wr(ldc_pkg::ADDR_TH1, 8'hFF);
    wr(ldc_pkg::ADDR_TL0, 8'h00);
    wr(ldc_pkg::ADDR_TH0, 8'hF0);
    wr(ldc_pkg::ADDR_CKSEL, 8'h0C);
    wr(ldc_pkg::ADDR_MODE, 8'h13);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1;
      n_ovf += int'(ovf1);
      n_irq += int'(irq1);
    end
    chk("t1 rate pulse", 8'h01, {7'h00, n_ovf != 0});
    chk("t1 no flag", 8'h00, {7'h00, n_irq != 0});
    wr(ldc_pkg::ADDR_CTRL, 8'h40);
    for (int i = 0; i < 40 && irq1 !== 1'b1; i++) @(posedge clk_i);
    #1;
    chk("split high irq", 8'h01, {7'h00, irq1});
    if (irq1 !== 1'b1) report_and_stop();
    // The vector acknowledge clears the flag that the split high byte set.
    @(posedge clk_i) ack1 <= 1'b1;
    @(posedge clk_i) ack1 <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("irq1 acked", 8'h00, {7'h00, irq1});
    chk("split low idle", 8'h00, {7'h00, irq0});
    rd(ldc_pkg::ADDR_TL0, 8'hFF, 8'h00, "tl0 split");
    wr(ldc_pkg::ADDR_MODE, 8'h33);
    wr(ldc_pkg::ADDR_TL1, 8'h40);
    cyc(10);
    rd(ldc_pkg::ADDR_TL1, 8'hFF, 8'h40, "t1 mode3");
    $display("test split done");
  endtask : t_split
  // Main sequence: reset for 8 cycles, then every scenario.
  initial begin
    req = '0;
    rst_i = 1'b1;
    {ev_load, osc_en, g0, ack0, ack1, en1} = 6'h00;
    {g1, pol0, en0} = 3'h7;
    pol1 = 1'b0;
    ev0_n = 8'h00;
    ev1_n = 8'h00;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_mode16();
    t_mode13();
    t_reload();
    t_prescale();
    t_counter();
    t_split();
    report_and_stop();
  end
endmodule : test_legacy_dual_counter_timer
`default_nettype wire
